// ==== common/tsc_consts.vh ====
// constants for the touch converter serial sequencer
// assumes a single 40 MHz system clock sampling the serial pins
`ifndef TSC_CONSTS_VH
`define TSC_CONSTS_VH
// control byte field positions (msb first on the wire)
`define TSC_CB_START 7
`define TSC_CB_CH_HI 6
`define TSC_CB_CH_LO 4
`define TSC_CB_MODE 3
`define TSC_CB_REFKIND 2
`define TSC_CB_PD1 1
`define TSC_CB_PD0 0
// result widths
`define TSC_RES12 12
`define TSC_RES8 8
// sample hold limit in ns and derived 40 MHz cycles (rounded down)
`define TSC_HOLD_NS 1600000
`define TSC_CLK_NS 25
`define TSC_HOLD_CYC (`TSC_HOLD_NS / `TSC_CLK_NS)
// power state reset values: powered after power-up, reference on
`define TSC_ADC_PWR_RST 1'b1
`define TSC_REF_PWR_RST 1'b1
`endif

// ==== core/tsc_pin_sync.v ====
// three-stage synchroniser with agreement filter for one pin
// assumes input is asynchronous to clk_in; output changes once stages 2 and 3 agree
module tsc_pin_sync #(
	parameter RST_VAL = 1'b0
) (
	input wire clk_in,
	input wire rst_n_in,
	input wire pin_in,
	output reg level_out
);
	reg s1_r; // first stage, read only by s2
	reg s2_r;
	reg s3_r;
	// shift chain and agreement filter
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s1_r <= RST_VAL;
			s2_r <= RST_VAL;
			s3_r <= RST_VAL;
			level_out <= RST_VAL;
		end else begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				level_out <= s3_r; // stable value only
			end
		end
	end
endmodule

// ==== core/tsc_serial_conv.v ====
// serial conversion sequencer of a touch-screen converter (digital side)
// assumes host drives serial clock, chip select and data in; sampled on CLK_IN
`include "tsc_consts.vh"
module tsc_serial_conv #(
	parameter HOLD_CYC = `TSC_HOLD_CYC
) (
	input wire CLK_IN,
	input wire RST_N_IN,
	input wire SERIAL_CLOCK_IN,
	input wire CS_N_IN,
	input wire DATA_IN,
	input wire [11:0] SAMPLE_IN,
	output reg DATA_OUT,
	output reg DATA_OE_OUT,
	output reg BUSY_OUT,
	output reg BUSY_OE_OUT,
	output reg [2:0] CHANNEL_OUT,
	output reg REFERENCE_KIND_SEL_OUT,
	output reg ADC_POWER_OUT,
	output reg REFERENCE_POWER_OUT,
	output reg SAMPLE_HOLD_OUT,
	output reg HOLD_TIMEOUT_OUT
);
	// sequencer states
	localparam ST_IDLE = 2'b00;
	localparam ST_CMD = 2'b01;
	localparam ST_BUSY = 2'b10;
	localparam ST_SHIFT = 2'b11;
	wire sclk_s; // filtered serial clock
	wire cs_n_s; // filtered chip select
	wire din_s; // filtered data in
	reg sclk_d_r; // previous filtered clock for edge detect
	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg [2:0] cmd_cnt_r; // control bits taken after the start bit
	reg [6:0] cmd_sr_r; // control bits after start
	reg [3:0] bit_cnt_r; // result bits still to send
	reg [11:0] res_sr_r; // result shift register
	reg mode8_r; // pending resolution of current conversion
	reg pd1_pend_r; // reference setting waiting for busy
	reg pd0_r; // adc power select of current byte
	reg [22:0] hold_cnt_r; // cycles since conversion start
	reg cs_n_d_r; // previous filtered select, idles high like the pin
	reg cmd_armed_r; // next start bit taken while result shifts
	wire rise;
	wire fall;
	// pins pass four flops before use
	tsc_pin_sync #(.RST_VAL(1'b0)) u_sclk (.clk_in(CLK_IN), .rst_n_in(RST_N_IN), .pin_in(SERIAL_CLOCK_IN),
		.level_out(sclk_s));
	tsc_pin_sync #(.RST_VAL(1'b1)) u_cs (.clk_in(CLK_IN), .rst_n_in(RST_N_IN), .pin_in(CS_N_IN),
		.level_out(cs_n_s));
	tsc_pin_sync #(.RST_VAL(1'b0)) u_din (.clk_in(CLK_IN), .rst_n_in(RST_N_IN), .pin_in(DATA_IN),
		.level_out(din_s));
	assign rise = sclk_s & ~sclk_d_r;
	assign fall = ~sclk_s & sclk_d_r;
	// result width from mode
	function [3:0] res_len;
		input m8;
		begin
			res_len = m8 ? 4'd8 : 4'd12;
		end
	endfunction
	// next state logic
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (rise && din_s) begin
					state_nxt = ST_CMD; // start bit seen
				end
			end
			ST_CMD: begin
				if (rise && cmd_cnt_r == 3'd6) begin
					state_nxt = ST_BUSY; // control byte complete
				end
			end
			ST_BUSY: begin
				if (fall) begin
					state_nxt = ST_SHIFT; // half a serial clock of busy then data
				end
			end
			ST_SHIFT: begin
				if (fall && bit_cnt_r == 4'd1) begin
					if (cmd_armed_r) begin
						state_nxt = ST_CMD; // overlapped byte keeps its count
					end else begin
						state_nxt = ST_IDLE; // end after last bit
					end
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end
	// main sequencer
	always @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			sclk_d_r <= 1'b0;
			cs_n_d_r <= 1'b1;
			cmd_armed_r <= 1'b0;
			state_r <= ST_IDLE;
			cmd_cnt_r <= 3'd0;
			cmd_sr_r <= 7'h00;
			bit_cnt_r <= 4'd0;
			res_sr_r <= 12'h000;
			mode8_r <= 1'b0;
			pd1_pend_r <= `TSC_REF_PWR_RST;
			pd0_r <= `TSC_ADC_PWR_RST;
			hold_cnt_r <= 23'd0;
			DATA_OUT <= 1'b0;
			DATA_OE_OUT <= 1'b0;
			BUSY_OUT <= 1'b0;
			BUSY_OE_OUT <= 1'b0;
			CHANNEL_OUT <= 3'h0;
			REFERENCE_KIND_SEL_OUT <= 1'b0;
			ADC_POWER_OUT <= `TSC_ADC_PWR_RST; // powered from reset
			REFERENCE_POWER_OUT <= `TSC_REF_PWR_RST;
			SAMPLE_HOLD_OUT <= 1'b0;
			HOLD_TIMEOUT_OUT <= 1'b0;
		end else begin
			sclk_d_r <= sclk_s;
			cs_n_d_r <= cs_n_s;
			DATA_OE_OUT <= ~cs_n_s;
			BUSY_OE_OUT <= ~cs_n_s;
			if (cs_n_s) begin
				// abort conversion, adc down, reference untouched
				state_r <= ST_IDLE;
				cmd_cnt_r <= 3'd0;
				bit_cnt_r <= 4'd0;
				BUSY_OUT <= 1'b0;
				DATA_OUT <= 1'b0;
				cmd_armed_r <= 1'b0;
				// power drops on the select edge only: deselected from reset stays powered
				if (!cs_n_d_r) begin
					ADC_POWER_OUT <= 1'b0;
				end
				SAMPLE_HOLD_OUT <= 1'b0;
				hold_cnt_r <= 23'd0;
			end else begin
				state_r <= state_nxt;
				// hold time watch while sample is held
				if (SAMPLE_HOLD_OUT) begin
					if (hold_cnt_r == HOLD_CYC[22:0]) begin
						HOLD_TIMEOUT_OUT <= 1'b1; // host overran hold limit
					end else begin
						hold_cnt_r <= hold_cnt_r + 23'd1;
					end
				end
				case (state_r)
					ST_IDLE: begin
						cmd_cnt_r <= 3'd0;
						if (rise && din_s) begin
							ADC_POWER_OUT <= 1'b1; // wake instantly on new byte
						end
					end
					ST_CMD: begin
						if (rise) begin
							cmd_sr_r <= {cmd_sr_r[5:0], din_s};
							cmd_cnt_r <= cmd_cnt_r + 3'd1;
							if (cmd_cnt_r == 3'd6) begin
								// last bit: busy rises, fields take effect
								CHANNEL_OUT <= cmd_sr_r[5:3];
								mode8_r <= cmd_sr_r[2];
								REFERENCE_KIND_SEL_OUT <= cmd_sr_r[1];
								pd0_r <= din_s;
								pd1_pend_r <= cmd_sr_r[0];
								ADC_POWER_OUT <= 1'b1;
							end
						end
					end
					ST_BUSY: begin
						if (!BUSY_OUT) begin
							BUSY_OUT <= 1'b1;
							REFERENCE_POWER_OUT <= pd1_pend_r; // latched as busy rises
							SAMPLE_HOLD_OUT <= 1'b1;
							hold_cnt_r <= 23'd0;
							HOLD_TIMEOUT_OUT <= 1'b0;
						end
						if (fall) begin
							BUSY_OUT <= 1'b0;
							// straight binary, msb aligned
							res_sr_r <= mode8_r ? {SAMPLE_IN[11:4], 4'h0} : SAMPLE_IN;
							DATA_OUT <= SAMPLE_IN[11];
							bit_cnt_r <= res_len(mode8_r);
						end
					end
					ST_SHIFT: begin
						ADC_POWER_OUT <= 1'b1; // powered even with clock paused
						// overlapped next control byte, counted on so the byte stays aligned
						if (rise && din_s && !cmd_armed_r) begin
							cmd_armed_r <= 1'b1; // start bit
							cmd_cnt_r <= 3'd0;
						end else if (rise && cmd_armed_r && cmd_cnt_r != 3'd6) begin
							cmd_sr_r <= {cmd_sr_r[5:0], din_s};
							cmd_cnt_r <= cmd_cnt_r + 3'd1;
						end
						if (fall) begin
							res_sr_r <= {res_sr_r[10:0], 1'b0};
							DATA_OUT <= res_sr_r[10]; // msb first
							bit_cnt_r <= bit_cnt_r - 4'd1;
							if (bit_cnt_r == 4'd1) begin
								SAMPLE_HOLD_OUT <= 1'b0;
								DATA_OUT <= 1'b0;
								ADC_POWER_OUT <= pd0_r; // auto-down when cleared
								cmd_armed_r <= 1'b0; // pending byte continues in command state
							end
						end
					end
					default: begin
						cmd_cnt_r <= 3'd0;
					end
				endcase
			end
		end
	end
endmodule

// ==== testbench/tsc_serial_conv_monitor.sv ====
// port checker for the serial conversion sequencer
// assumes one clock and an active-low async reset
module tsc_serial_conv_monitor (
	input wire CLK_IN,
	input wire RST_N_IN,
	input wire CS_N_IN,
	input wire BUSY_OUT,
	input wire BUSY_OE_OUT,
	input wire DATA_OE_OUT,
	input wire ADC_POWER_OUT,
	input wire REFERENCE_POWER_OUT,
	input wire SAMPLE_HOLD_OUT,
	input wire HOLD_TIMEOUT_OUT
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	property p_rst; $rose(RST_N_IN) |-> ADC_POWER_OUT && REFERENCE_POWER_OUT; endproperty
	a_rst: assert property (p_rst) else $error("power after reset");
	property p_cs; $rose(CS_N_IN) ##1 CS_N_IN[*6] |-> !ADC_POWER_OUT && !SAMPLE_HOLD_OUT; endproperty
	a_cs: assert property (p_cs) else $error("select high kept power");
	property p_oe; CS_N_IN[*6] |-> !BUSY_OE_OUT && !DATA_OE_OUT && !BUSY_OUT; endproperty
	a_oe: assert property (p_oe) else $error("driving while deselected");
	property p_ref; CS_N_IN[*6] |=> $stable(REFERENCE_POWER_OUT); endproperty
	a_ref: assert property (p_ref) else $error("reference moved");
	property p_hld; SAMPLE_HOLD_OUT |-> ADC_POWER_OUT; endproperty
	a_hld: assert property (p_hld) else $error("unpowered while holding");
	property p_bsy; $rose(BUSY_OUT) |-> BUSY_OUT[*4] ##[1:40] !BUSY_OUT; endproperty
	a_bsy: assert property (p_bsy) else $error("busy length");
	property p_lat; $changed(REFERENCE_POWER_OUT) |-> BUSY_OUT || $past(BUSY_OUT); endproperty
	a_lat: assert property (p_lat) else $error("reference latched off busy");
	property p_tmo; $rose(BUSY_OUT) |-> ##[0:2] !HOLD_TIMEOUT_OUT; endproperty
	a_tmo: assert property (p_tmo) else $error("timeout not cleared");
	c_bsy: cover property ($rose(BUSY_OUT));
	c_tmo: cover property ($rose(HOLD_TIMEOUT_OUT));
	c_pd: cover property ($fell(ADC_POWER_OUT));
endmodule
bind tsc_serial_conv tsc_serial_conv_monitor tsc_serial_conv_monitor_inst (.*);

// ==== testbench/tsc_host_model.sv ====
// host model: frames serial clock, select and control bits
// assumes the converter samples these pins on clk_in
module tsc_host_model (
	input wire logic clk_in,
	input wire logic dout_in,
	input wire logic [1:0] st_in,
	output logic sck_out,
	output logic cs_n_out,
	output logic din_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [63:0] cap; // result bit seen before each rise
	logic [1:0] st [64]; // power and hold seen before each rise
	event fin; // frame done, samples ready
	int hp = 8; // serial half period in clk cycles
	initial begin
		sck_out = 1'b0;
		cs_n_out = 1'b1;
		din_out = 1'b0;
	end
	// half a serial period, then the usual small delay
	task automatic half();
		repeat (hp) @(posedge clk_in);
		#2;
	endtask
	// one frame: stream msb first, optional stall, optional abort
	task automatic frame(input logic [47:0] s, input int n, gap, ab);
		cs_n_out = 1'b0;
		for (int i = 1; i <= n; i++) begin
			din_out = s[48 - i]; // next bit rides on data
			if (i == gap) repeat (300) @(posedge clk_in); // stall past limit
			half();
			if (i == ab) break;
			cap[i] = dout_in;
			st[i] = st_in;
			sck_out = 1'b1;
			half();
			sck_out = 1'b0;
		end
		din_out = ~din_out; // inverted line, not left at last bit
		half();
		cs_n_out = 1'b1;
		->fin;
		half();
	endtask
endmodule

// ==== testbench/testbench.sv ====
// self-checking bench for the serial conversion sequencer
// assumes the host model drives the pins and captures replies
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {int p; int w; logic [11:0] v;} note_t;
	note_t q[$]; // expected results, oldest first
	int failures = 0, comparisons = 0, seed = 32'hdd92;
	logic CLK_IN = 0, RST_N_IN = 0;
	logic [11:0] smp = 0;
	wire sck, cs_n, din, dout, hold, pwr, rpw, tmo, ks;
	wire [2:0] ch;
	always #12.5 CLK_IN = ~CLK_IN;
	tsc_serial_conv #(.HOLD_CYC(250)) tsc_serial_conv_inst (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
		.SERIAL_CLOCK_IN(sck), .CS_N_IN(cs_n), .DATA_IN(din), .SAMPLE_IN(smp), .DATA_OUT(dout),
		.DATA_OE_OUT(), .BUSY_OUT(), .BUSY_OE_OUT(), .CHANNEL_OUT(ch), .REFERENCE_KIND_SEL_OUT(ks),
		.ADC_POWER_OUT(pwr), .REFERENCE_POWER_OUT(rpw), .SAMPLE_HOLD_OUT(hold), .HOLD_TIMEOUT_OUT(tmo));
	tsc_host_model host_inst (.clk_in(CLK_IN), .dout_in(dout), .st_in({pwr, hold}), .sck_out(sck),
		.cs_n_out(cs_n), .din_out(din));
	task automatic chk(input logic [11:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// msb first result from the bits captured at rises p on
	function automatic logic [11:0] bits(input int p, w);
		logic [11:0] r;
		r = 12'h0;
		for (int k = 0; k < w; k++) r = {r[10:0], host_inst.cap[p + k]};
		return r;
	endfunction
	function automatic void push(input int p, input logic [7:0] c);
		q.push_back('{p, c[3] ? 8 : 12, c[3] ? {4'h0, smp[11:4]} : smp});
	endfunction
	// frame with two idle zeros, second byte o clocks behind
	task automatic run(input logic [7:0] c1, c2, input int o, gap, ab);
		smp = 12'($random(seed));
		if (ab == 0) push(11, c1);
		if (c2[7]) push(o + 11, c2);
		host_inst.frame(({c1, 40'h0} >> 2) | ({c2, 40'h0} >> (o + 2)), 46, gap, ab);
	endtask
	// compare queued notes once a frame finishes
	always @(host_inst.fin) begin
		note_t n;
		while (q.size() > 0) begin
			n = q.pop_front();
			chk(bits(n.p, n.w), n.v);
		end
	end
	initial begin
		repeat (4) @(posedge CLK_IN);
		#2 RST_N_IN = 1;
		repeat (6) @(posedge CLK_IN);
		chk(pwr, 1);
		for (int k = 0; k < 8; k++) begin
			run({1'b1, k[2:0], 1'b0, k[0], 1'b1, k[1]}, 0, 0, 0, 0);
			chk(ch, k[2:0]);
			chk(ks, k[0]);
			chk(host_inst.st[24][1], k[1]);
			chk(host_inst.st[20][0], 1);
		end
		run(8'h9b, 0, 0, 0, 0);
		chk(host_inst.st[20][0], 0);
		host_inst.hp = 6; // 8-bit frame clocked a third faster
		run(8'h9b, 0, 0, 0, 0);
		chk(host_inst.st[19][0], 0);
		host_inst.hp = 8;
		for (int o = 15; o <= 16; o++) run(8'h93, 8'h9b, o, 0, 0);
		run(8'h93, 0, 0, 0, 15);
		chk(pwr, 0);
		chk(rpw, 1);
		run(8'h91, 0, 0, 0, 0);
		chk(rpw, 0);
		run(8'h93, 0, 0, 14, 0);
		chk(tmo, 1);
		run(8'h93, 0, 0, 0, 0);
		chk(tmo, 0);
		chk(rpw, 1);
		close_out();
	end
	initial begin
		#1ms;
		failures++;
		close_out();
	end
endmodule
